/* hdl/tog_map.svh */
`ifndef TOG_MAP_SVH
`define TOG_MAP_SVH
// ----------------------------------------------------------------
// table geometry
// ----------------------------------------------------------------
`define TOG_NUM_TONES   7'h40
`define TOG_LAST_TONE   6'h3f
`define TOG_TONE_W      6
`define TOG_BITS_W      4
`define TOG_BMAX_LO     4'h8
`define TOG_BMAX_HI     4'hf
`define TOG_CNT_W       10
// ----------------------------------------------------------------
// gain factor, unsigned fixed point with 10 fraction bits
// ----------------------------------------------------------------
`define TOG_GAIN_W      12
`define TOG_GAIN_FRAC   10
`define TOG_GAIN_RST    12'h400
`define TOG_GAIN_MIN    12'h300
`define TOG_GAIN_MAX    12'h552
// ----------------------------------------------------------------
// datapath widths
// ----------------------------------------------------------------
`define TOG_PT_W        16
`define TOG_LAB_W       15
`define TOG_FIFO_DEPTH  8
`endif

/* hdl/tog_pkg.sv */
package tog_pkg;
  `include "tog_map.svh"
  typedef logic [`TOG_TONE_W-1:0]      tog_tone_t;
  typedef logic [`TOG_BITS_W-1:0]      tog_bits_t;
  typedef logic [`TOG_GAIN_W-1:0]      tog_gain_t;
  typedef logic signed [`TOG_PT_W-1:0] tog_pt_t;
  typedef logic [`TOG_LAB_W-1:0]       tog_lab_t;
  typedef logic [`TOG_CNT_W-1:0]       tog_cnt_t;
  typedef enum logic [1:0] {TOG_IDLE, TOG_ORDER, TOG_LOAD} tog_state_e;
endpackage : tog_pkg

/* hdl/tog_fifo.sv */
`timescale 1ns/10ps
module tog_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // ----------------------------------------------------------------
  // flags and pointers
  // ----------------------------------------------------------------
  always_comb begin
    in_ready  = (cnt_r != (AW+1)'(DEPTH));
    out_valid = (cnt_r != '0);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_nxt    = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt    = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    out_data  = mem[rp_r];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; empty flag guards reads
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  a_fifo_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : tog_fifo

/* hdl/tog_scaler.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - every encoder point is multiplied by its tone's gain factor before modulation.
// - per-tone gain spans about 0.75 to 1.33, roughly plus or minus 2.5 dB.
// - with dual latency, slow bits go on high-SNR tones, fast bits on small ones.
// - ordered mode loads all fast bits first on fewest-bit tones, then slow bits.
// - each tone carries exactly its allocation, except dual-latency tones above max, which get none; the boundary tone may mix sources.
// - ordered table steps k upward from 0 to max, appending tones of k bits ascending.
// - single latency skips ordering and fills tones from the lowest frequency upward.
// - buffer bits are taken LSB first; earliest bits land on the first ordered tone.
// - maximum bits per tone lies between 8 and 15 and bounds the ordering loop.
`include "tog_map.svh"
module tog_scaler
  import tog_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             tbl_wr_en,
  input  wire tog_pkg::tog_tone_t tbl_wr_tone,
  input  wire tog_pkg::tog_bits_t tbl_wr_bits,
  input  wire tog_pkg::tog_gain_t tbl_wr_gain,
  input  wire logic             dual_latency,
  input  wire tog_pkg::tog_bits_t bmax_in,
  input  wire tog_pkg::tog_cnt_t  fast_bits_sym,
  input  wire logic             sym_start,
  output logic                  busy,
  input  wire logic             fast_valid,
  input  wire logic             fast_bit,
  output logic                  fast_ready,
  input  wire logic             slow_valid,
  input  wire logic             slow_bit,
  output logic                  slow_ready,
  output logic                  lab_valid,
  input  wire logic             lab_ready,
  output tog_pkg::tog_tone_t    lab_tone,
  output tog_pkg::tog_bits_t    lab_bits,
  output tog_pkg::tog_lab_t     lab_value,
  input  wire logic             pt_valid,
  input  wire tog_pkg::tog_tone_t pt_tone,
  input  wire tog_pkg::tog_pt_t   pt_x,
  input  wire tog_pkg::tog_pt_t   pt_y,
  output logic                  sc_valid,
  output tog_pkg::tog_tone_t    sc_tone,
  output tog_pkg::tog_pt_t      sc_x,
  output tog_pkg::tog_pt_t      sc_y
);
  import tog_pkg::*;
  localparam int WORD_W = `TOG_TONE_W + `TOG_BITS_W + `TOG_LAB_W;
  localparam int PROD_W = `TOG_PT_W + `TOG_GAIN_W + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // scale one coordinate, saturating instead of wrapping on overflow
  function automatic tog_pt_t scale_sat(input tog_pt_t v, input tog_gain_t g);
    logic signed [PROD_W-1:0] p;
    logic signed [PROD_W-1:0] s;
    p = v * $signed({1'b0, g});
    s = p >>> `TOG_GAIN_FRAC;
    if (s > PROD_W'(32767)) begin
      scale_sat = 16'h7fff;
    end else if (s < -PROD_W'(32768)) begin
      scale_sat = 16'h8000;
    end else begin
      scale_sat = s[`TOG_PT_W-1:0];
    end
  endfunction : scale_sat

  // ----------------------------------------------------------------
  // tables
  // ----------------------------------------------------------------
  tog_bits_t  bits_mem [0:`TOG_NUM_TONES-1];
  tog_gain_t  gain_mem [0:`TOG_NUM_TONES-1];
  tog_tone_t  ord_mem  [0:`TOG_NUM_TONES-1];
  logic       tbl_we;
  tog_gain_t  gain_clip;
  tog_bits_t  bits_clip;

  tog_state_e state_r, state_nxt;
  logic       dual_r, dual_nxt;
  tog_bits_t  bmax_r, bmax_nxt;
  tog_bits_t  k_r, k_nxt;
  tog_tone_t  i_r, i_nxt;
  logic [6:0] wp_r, wp_nxt;
  logic [6:0] p_r, p_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  tog_bits_t  nb_r, nb_nxt;
  tog_lab_t   acc_r, acc_nxt;
  tog_cnt_t   fast_left_r, fast_left_nxt;
  logic       ord_we;
  tog_tone_t  cur_tone;
  tog_bits_t  cur_b;
  logic       use_fast, in_avail, in_bit, take, last_bit;
  logic       f_in_valid, f_in_ready;
  logic [WORD_W-1:0] f_in_data, f_out_data;

  // writes are only taken between symbols so a symbol never sees a change
  always_comb begin
    tbl_we    = tbl_wr_en && !busy;
    gain_clip = tbl_wr_gain;
    if (tbl_wr_gain < `TOG_GAIN_MIN) begin
      gain_clip = `TOG_GAIN_MIN;
    end else if (tbl_wr_gain > `TOG_GAIN_MAX) begin
      gain_clip = `TOG_GAIN_MAX;
    end
    bits_clip = tbl_wr_bits;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int t = 0; t < `TOG_NUM_TONES; t++) begin
        bits_mem[t] <= '0;
        gain_mem[t] <= `TOG_GAIN_RST;
      end
    end else if (tbl_we) begin
      bits_mem[tbl_wr_tone] <= bits_clip;
      gain_mem[tbl_wr_tone] <= gain_clip;
    end
  end

  // ordered table; entries past the write pointer are never read
  always_ff @(posedge sys_clk) begin
    if (ord_we) begin
      ord_mem[wp_r[5:0]] <= i_r;
    end
  end

  // ----------------------------------------------------------------
  // ordering and bit loading sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    dual_nxt      = dual_r;
    bmax_nxt      = bmax_r;
    k_nxt         = k_r;
    i_nxt         = i_r;
    wp_nxt        = wp_r;
    p_nxt         = p_r;
    cnt_nxt       = cnt_r;
    nb_nxt        = nb_r;
    acc_nxt       = acc_r;
    fast_left_nxt = fast_left_r;
    ord_we        = 1'b0;
    cur_tone      = dual_r ? ord_mem[p_r[5:0]] : p_r[5:0];
    cur_b         = bits_mem[cur_tone];
    use_fast      = !dual_r || (fast_left_r != '0);
    in_avail      = use_fast ? fast_valid : slow_valid;
    in_bit        = use_fast ? fast_bit : slow_bit;
    last_bit      = (nb_r == cur_b - 4'h1);
    take          = 1'b0;
    fast_ready    = 1'b0;
    slow_ready    = 1'b0;
    f_in_valid    = 1'b0;
    f_in_data     = '0;
    unique case (state_r)
      TOG_IDLE: begin
        if (sym_start) begin
          dual_nxt      = dual_latency;
          // clamp below the agreed floor; the ceiling is the field width
          bmax_nxt      = (bmax_in < `TOG_BMAX_LO) ? `TOG_BMAX_LO : bmax_in;
          fast_left_nxt = fast_bits_sym;
          k_nxt         = '0;
          i_nxt         = '0;
          wp_nxt        = '0;
          p_nxt         = '0;
          nb_nxt        = '0;
          acc_nxt       = '0;
          cnt_nxt       = `TOG_NUM_TONES;
          state_nxt     = dual_latency ? TOG_ORDER : TOG_LOAD;
        end
      end
      TOG_ORDER: begin
        // one tone examined per cycle, k outer, tone index inner
        ord_we = (bits_mem[i_r] == k_r);
        if (ord_we) begin
          wp_nxt = wp_r + 7'h1;
        end
        i_nxt = i_r + 6'h1;
        if (i_r == `TOG_LAST_TONE) begin
          k_nxt = k_r + 4'h1;
          if (k_r == bmax_r) begin
            cnt_nxt   = ord_we ? wp_r + 7'h1 : wp_r;
            state_nxt = TOG_LOAD;
          end
        end
      end
      TOG_LOAD: begin
        if (p_r == cnt_r) begin
          state_nxt = TOG_IDLE;
        end else if (cur_b == '0) begin
          p_nxt = p_r + 7'h1;
        end else begin
          // bits are only pulled while a finished word could be stored
          fast_ready = use_fast && f_in_ready;
          slow_ready = !use_fast && f_in_ready;
          take       = in_avail && f_in_ready;
          if (take) begin
            acc_nxt = acc_r | (tog_lab_t'(in_bit) << nb_r);
            if (use_fast && dual_r) begin
              fast_left_nxt = fast_left_r - 10'h1;
            end
            if (last_bit) begin
              // boundary tone may hold fast bits low and slow bits high
              f_in_valid = 1'b1;
              f_in_data  = {cur_tone, cur_b, acc_nxt};
              acc_nxt    = '0;
              nb_nxt     = '0;
              p_nxt      = p_r + 7'h1;
            end else begin
              nb_nxt = nb_r + 4'h1;
            end
          end
        end
      end
    endcase
    busy = (state_r != TOG_IDLE);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= TOG_IDLE;
      dual_r      <= 1'b0;
      bmax_r      <= `TOG_BMAX_LO;
      k_r         <= '0;
      i_r         <= '0;
      wp_r        <= '0;
      p_r         <= '0;
      cnt_r       <= '0;
      nb_r        <= '0;
      acc_r       <= '0;
      fast_left_r <= '0;
    end else begin
      state_r     <= state_nxt;
      dual_r      <= dual_nxt;
      bmax_r      <= bmax_nxt;
      k_r         <= k_nxt;
      i_r         <= i_nxt;
      wp_r        <= wp_nxt;
      p_r         <= p_nxt;
      cnt_r       <= cnt_nxt;
      nb_r        <= nb_nxt;
      acc_r       <= acc_nxt;
      fast_left_r <= fast_left_nxt;
    end
  end

  // ----------------------------------------------------------------
  // label buffer toward the constellation encoder
  // ----------------------------------------------------------------
  tog_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (`TOG_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (lab_valid),
    .out_ready (lab_ready),
    .out_data  (f_out_data)
  );

  assign lab_tone  = f_out_data[WORD_W-1 -: `TOG_TONE_W];
  assign lab_bits  = f_out_data[`TOG_LAB_W +: `TOG_BITS_W];
  assign lab_value = f_out_data[`TOG_LAB_W-1:0];

  // ----------------------------------------------------------------
  // fine gain scaling, one cycle latency
  // ----------------------------------------------------------------
  logic      sc_valid_nxt;
  tog_tone_t sc_tone_nxt;
  tog_pt_t   sc_x_nxt, sc_y_nxt;

  // results hold between points so a slow modulator can still read them
  always_comb begin
    sc_valid_nxt = pt_valid;
    sc_tone_nxt  = pt_valid ? pt_tone : sc_tone;
    sc_x_nxt     = pt_valid ? scale_sat(pt_x, gain_mem[pt_tone]) : sc_x;
    sc_y_nxt     = pt_valid ? scale_sat(pt_y, gain_mem[pt_tone]) : sc_y;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sc_valid <= 1'b0;
      sc_tone  <= '0;
      sc_x     <= '0;
      sc_y     <= '0;
    end else begin
      sc_valid <= sc_valid_nxt;
      sc_tone  <= sc_tone_nxt;
      sc_x     <= sc_x_nxt;
      sc_y     <= sc_y_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_scale_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pt_valid |=> sc_valid && sc_tone == $past(pt_tone)) else $error("scaled point missing");
  a_scale_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pt_valid && pt_x == '0 |=> sc_x == '0) else $error("zero point scaled to nonzero");
  a_gain_bounds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tbl_we |=> gain_mem[$past(tbl_wr_tone)] >= `TOG_GAIN_MIN
               && gain_mem[$past(tbl_wr_tone)] <= `TOG_GAIN_MAX) else $error("gain out of range");
  a_fast_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
    slow_ready |-> dual_r && fast_left_r == '0) else $error("slow bit before fast done");
  a_one_source: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(fast_ready && slow_ready)) else $error("both buffers pulled");
  a_exact_bits: assert property (@(posedge sys_clk) disable iff (!reset_n)
    f_in_valid |-> nb_r == cur_b - 4'h1 && cur_b != '0) else $error("tone bit count wrong");
  a_order_mono: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_r == TOG_LOAD && dual_r && p_r != '0 && p_r < cnt_r
    |-> bits_mem[ord_mem[p_r[5:0]]] >= bits_mem[ord_mem[p_r[5:0] - 6'h1]])
    else $error("ordered table not ascending");
  a_single_plain: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_r == TOG_ORDER |-> dual_r) else $error("single latency was reordered");
  a_lsb_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && nb_r == '0 && !last_bit |=> acc_r[0] == $past(in_bit))
    else $error("first bit not lsb");
  a_bmax_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
    bmax_r >= `TOG_BMAX_LO && bmax_r <= `TOG_BMAX_HI) else $error("max bits out of range");
  a_tables_frozen: assert property (@(posedge sys_clk) disable iff (!reset_n)
    busy && tbl_wr_en |=> bits_mem[$past(tbl_wr_tone)] == $past(bits_mem[tbl_wr_tone]))
    else $error("table changed mid symbol");
endmodule : tog_scaler

/* sim/tog_partner.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// framer buffers and label sink beside the scaler
// ----------------------------------------------------------------
module tog_partner
  import tog_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               rewind,
  input  wire logic               slow_mode,
  input  wire logic               hold,
  input  wire logic [31:0]        fast_pat,
  input  wire logic [31:0]        slow_pat,
  output logic                    fast_valid,
  output logic                    fast_bit,
  input  wire logic               fast_ready,
  output logic                    slow_valid,
  output logic                    slow_bit,
  input  wire logic               slow_ready,
  input  wire logic               lab_valid,
  output logic                    lab_ready,
  input  wire tog_pkg::tog_tone_t lab_tone,
  input  wire tog_pkg::tog_bits_t lab_bits,
  input  wire tog_pkg::tog_lab_t  lab_value
);
  int         fi;
  int         si;
  int         n;
  logic [2:0] cyc;
  logic       ftk;
  logic       stk;
  tog_tone_t  cap_tone [32];
  tog_bits_t  cap_bits [32];
  tog_lab_t   cap_val  [32];
  // handshakes judged on values at the edge, drives move 1 ns later
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fi = 0;
      si = 0;
      n = 0;
      cyc = 3'h0;
      fast_valid = 1'b0;
      slow_valid = 1'b0;
      fast_bit = 1'b0;
      slow_bit = 1'b0;
      lab_ready = 1'b0;
    end else begin
      ftk = fast_valid && fast_ready;
      stk = slow_valid && slow_ready;
      if (lab_valid && lab_ready && n < 32) begin
        // each word names its own tone, so no ordering table has to cross
        cap_tone[n] = lab_tone;
        cap_bits[n] = lab_bits;
        cap_val[n] = lab_value;
        n++;
      end
      fi = rewind ? 0 : fi + int'(ftk);
      si = rewind ? 0 : si + int'(stk);
      if (rewind) n = 0;
      cyc++;
      #1;
      // valid may only pause right after a take, never while offered
      if (ftk || !fast_valid) fast_valid = !(slow_mode && cyc[0]);
      if (stk || !slow_valid) slow_valid = !(slow_mode && cyc[1]);
      // idle lines show the inverse so a stale bit never passes for data
      fast_bit = fast_valid ? fast_pat[fi%32] : !fast_pat[fi%32];
      slow_bit = slow_valid ? slow_pat[si%32] : !slow_pat[si%32];
      lab_ready = !hold && !(slow_mode && cyc[2]);
    end
  end
endmodule : tog_partner

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import tog_pkg::*;
  typedef struct {tog_tone_t t; tog_gain_t g; tog_pt_t x, y, ex, ey;} tog_row_s;
  logic sys_clk = 1'b0, reset_n = 1'b0, tbl_wr_en = 1'b0, dual_latency = 1'b0;
  logic sym_start = 1'b0, pt_valid = 1'b0, rewind = 1'b0, slow_mode = 1'b0, hold = 1'b0;
  tog_tone_t tbl_wr_tone = '0, pt_tone = '0, lab_tone, sc_tone;
  tog_bits_t tbl_wr_bits = '0, bmax_in = 4'h8, lab_bits;
  tog_gain_t tbl_wr_gain = 12'h400;
  tog_cnt_t  fast_bits_sym = '0;
  tog_pt_t   pt_x = '0, pt_y = '0, sc_x, sc_y;
  tog_lab_t  lab_value;
  logic      busy, fast_valid, fast_bit, fast_ready, slow_valid, slow_bit, slow_ready;
  logic      lab_valid, lab_ready, sc_valid;
  int        errors = 0, cmp_count = 0, k;
  // tone, gain written, point in, scaled point expected
  tog_row_s  rows [6] = '{'{6'h32, 12'h400, 100, -100, 100, -100},
                         '{6'h33, 12'h300, 100, 40, 75, 30},
                         '{6'h34, 12'h552, 100, -3, 133, -4},
                         '{6'h35, 12'h200, -100, 1024, -75, 768},
                         '{6'h36, 12'hfff, 32767, -32768, 32767, -32768},
                         '{6'h37, 12'h552, 0, 7, 0, 9}};

  always #12.5 sys_clk = ~sys_clk;

  tog_scaler i_tog_scaler (.sys_clk(sys_clk), .reset_n(reset_n), .tbl_wr_en(tbl_wr_en),
    .tbl_wr_tone(tbl_wr_tone), .tbl_wr_bits(tbl_wr_bits), .tbl_wr_gain(tbl_wr_gain),
    .dual_latency(dual_latency), .bmax_in(bmax_in), .fast_bits_sym(fast_bits_sym),
    .sym_start(sym_start), .busy(busy), .fast_valid(fast_valid), .fast_bit(fast_bit),
    .fast_ready(fast_ready), .slow_valid(slow_valid), .slow_bit(slow_bit),
    .slow_ready(slow_ready), .lab_valid(lab_valid), .lab_ready(lab_ready),
    .lab_tone(lab_tone), .lab_bits(lab_bits), .lab_value(lab_value), .pt_valid(pt_valid),
    .pt_tone(pt_tone), .pt_x(pt_x), .pt_y(pt_y), .sc_valid(sc_valid), .sc_tone(sc_tone),
    .sc_x(sc_x), .sc_y(sc_y));

  tog_partner i_tog_partner (.sys_clk(sys_clk), .reset_n(reset_n), .rewind(rewind),
    .slow_mode(slow_mode), .hold(hold), .fast_pat(32'h0000_00ad), .slow_pat(32'h0000_0006),
    .fast_valid(fast_valid), .fast_bit(fast_bit), .fast_ready(fast_ready),
    .slow_valid(slow_valid), .slow_bit(slow_bit), .slow_ready(slow_ready),
    .lab_valid(lab_valid), .lab_ready(lab_ready), .lab_tone(lab_tone),
    .lab_bits(lab_bits), .lab_value(lab_value));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      errors++;
    end
  endtask : check

  // caller lowers the strobe after the last write, so it never toggles twice in a step
  task automatic wr(input tog_tone_t t, input tog_bits_t b, input tog_gain_t g);
    tbl_wr_en = 1'b1;
    tbl_wr_tone = t;
    tbl_wr_bits = b;
    tbl_wr_gain = g;
    tick;
  endtask : wr

  task automatic pt(input tog_tone_t t, input tog_pt_t x, y, ex, ey);
    pt_valid = 1'b1;
    pt_tone = t;
    pt_x = x;
    pt_y = y;
    tick;
    pt_valid = 1'b0;
    pt_x = ~x;
    check("sc_valid", 1, sc_valid);
    check("sc_tone", 32'(t), 32'(sc_tone));
    check("sc_x", 32'(ex), 32'(sc_x));
    check("sc_y", 32'(ey), 32'(sc_y));
    tick;
    check("sc_valid_drop", 0, sc_valid);
  endtask : pt

  task automatic sym(input logic d, input tog_cnt_t nf);
    rewind = 1'b1;
    tick;
    rewind = 1'b0;
    dual_latency = d;
    fast_bits_sym = nf;
    sym_start = 1'b1;
    tick;
    sym_start = 1'b0;
    check("busy_rise", 1, busy);
  endtask : sym

  // bounded waits: first for the symbol to finish, then for the sink to drain
  task automatic finish_sym(input int want);
    for (k = 0; k < 3000 && busy !== 1'b0; k++) tick;
    check("busy_cleared", 1, k < 3000);
    for (k = 0; k < 300 && i_tog_partner.n < want; k++) tick;
    check("word_count", want, i_tog_partner.n);
  endtask : finish_sym

  task automatic cmp_words(input int t[4], input int b[4], input int v[4]);
    for (int i = 0; i < 4; i++) begin
      check("lab_tone", t[i], 32'(i_tog_partner.cap_tone[i]));
      check("lab_bits", b[i], 32'(i_tog_partner.cap_bits[i]));
      check("lab_value", v[i], 32'(i_tog_partner.cap_val[i]));
    end
  endtask : cmp_words

  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // watchdog, well beyond the four symbols the run needs
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    results;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    check("reset_outputs", 0, {busy, lab_valid, sc_valid, fast_ready, slow_ready});
    reset_n = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].t, 4'h0, rows[i].g);
      tbl_wr_en = 1'b0;
      pt(rows[i].t, rows[i].x, rows[i].y, rows[i].ex, rows[i].ey);
    end
    $display("test gain rows done");
    // ordered symbol: fast bits fill the smallest tones, the boundary tone mixes sources
    wr(6'h01, 4'h1, 12'h400);
    wr(6'h05, 4'h2, 12'h400);
    wr(6'h09, 4'h2, 12'h400);
    wr(6'h02, 4'h3, 12'h400);
    tbl_wr_en = 1'b0;
    slow_mode = 1'b1;
    bmax_in = 4'h3;
    sym(1'b1, 10'h004);
    wr(6'h3f, 4'h1, 12'h300);
    tbl_wr_en = 1'b0;
    // a floor of 8 keeps ordering busy for 9 passes over the 64 tones
    repeat (400) tick;
    check("order_span", 1, busy);
    finish_sym(4);
    cmp_words('{1, 5, 9, 2}, '{1, 2, 2, 3}, '{1, 2, 1, 3});
    check("fast_taken", 4, i_tog_partner.fi);
    check("slow_taken", 4, i_tog_partner.si);
    pt(6'h3f, 100, -100, 100, -100);
    $display("test ordered symbol done");
    // single latency: ascending tones, fast stream only
    slow_mode = 1'b0;
    sym(1'b0, 10'h000);
    finish_sym(4);
    cmp_words('{1, 2, 5, 9}, '{1, 3, 2, 2}, '{1, 6, 2, 2});
    check("fast_taken", 8, i_tog_partner.fi);
    check("slow_taken", 0, i_tog_partner.si);
    $display("test single latency done");
    // fill the label buffer while the sink stalls, then drain it
    for (int i = 32; i < 44; i++) wr(6'(i), 4'h1, 12'h400);
    tbl_wr_en = 1'b0;
    hold = 1'b1;
    sym(1'b0, 10'h000);
    for (k = 0; k < 300 && i_tog_partner.fi < 12; k++) tick;
    repeat (20) tick;
    check("fast_taken_full", 12, i_tog_partner.fi);
    check("full_state", 3'h3, {fast_ready, lab_valid, busy});
    hold = 1'b0;
    finish_sym(16);
    check("last_tone", 43, 32'(i_tog_partner.cap_tone[15]));
    tick;
    check("drained", 0, lab_valid);
    $display("test buffer fill done");
    // reset in mid symbol returns the sequencer and the gain table to reset state
    sym(1'b1, 10'h000);
    reset_n = 1'b0;
    tick;
    check("mid_reset_busy", 0, busy);
    reset_n = 1'b1;
    pt(6'h34, 100, 0, 100, 0);
    $display("test mid reset done");
    results;
  end
endmodule : tb_top
